// *** hw/cantmc_ctrl.sv ***
`timescale 1ns/100ps
// Overview of operation
// - Normal mode: state follows transceiver mode field.
// - Sleep, and Standby with field other than 11: Offline or Offline Bias by activity.
// - Field 01 and 10 request Active.
// - Field 01: supply undervoltage leaves Active.
// - Field 10: ignore supply UV until reset.
// - Active needs Normal with active field, or Forced Normal (any field), supply ok.
// - Forced Normal, supply ok: Active.
// - Transmit pin low blocks Active; Listen-only.
// - Status bit shows transceiver ready.
// - Listen-only: transmitter off, receiver, bias on.
// - Normal/Standby with field 11: Listen-only.
// - Forced Normal, supply undervoltage: Listen-only.
// - Hold Listen-only on low pin or UV.
// - Offline: wake watch if enabled, ground bias.
// - Offline with bus activity goes Offline Bias.
// - Offline Bias returns after silence timeout.
// - Exit conditions to Offline via Bias if busy.
// - Inactive transceiver with activity: autonomous bias.
// - Off/Overtemp to Reset forces Offline.
module cantmc_ctrl #(
    parameter int SILENCE_CYCLES = cantmc_pkg::SILENCE_CYCLES
) (
    // Clock and reset.
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset,
    // Chip mode and software settings.
    input  wire logic [2:0] i_chip_mode_field,
    input  wire logic [1:0] i_transceiver_mode_field,
    input  wire logic       i_bus_wake_enable,
    // Supply indications.
    input  wire logic       i_transceiver_supply_uv,
    input  wire logic       i_supply1_below_reset_threshold,
    // Host transmit pin and bus activity.
    input  wire logic       i_transmit_data_pin,
    input  wire logic       i_bus_edge,
    // Transceiver controls.
    output logic            o_tx_enable,
    output logic            o_rx_enable,
    output logic            o_bias_supply,
    output logic            o_bias_auto,
    output logic            o_bias_ground,
    output logic            o_wake_monitor,
    // Status.
    output logic            o_transceiver_ready,
    output logic [3:0]      o_state
);

    cantmc_pkg::cantmc_state_type state_r;   // Current transceiver state.
    cantmc_pkg::cantmc_state_type state_nxt; // Next transceiver state.
    logic [2:0]                   mode_r;    // Chip mode seen last cycle.
    logic                         silent;    // Bus silent beyond timeout.
    logic                         want_act;  // Conditions call for Active.
    logic                         want_lst;  // Conditions call for Listen-only.
    logic                         tx_r, rx_r, bs_r, ba_r, bg_r, wm_r, rdy_r;
    logic                         tx_nxt, rx_nxt, bs_nxt, ba_nxt, bg_nxt, wm_nxt, rdy_nxt;

    // Silence timer instance.
    cantmc_silence #(
        .SILENCE_CYCLES (SILENCE_CYCLES)
    ) u_silence (
        .i_clk_sys  (i_clk_sys),
        .i_reset    (i_reset),
        .i_bus_edge (i_bus_edge),
        .o_silent   (silent)
    );

    // Decide which online state the inputs ask for.
    always_comb begin
        want_act = 1'b0;
        want_lst = 1'b0;
        if (i_chip_mode_field == cantmc_pkg::CHIP_NORMAL) begin
            if (i_transceiver_mode_field == cantmc_pkg::XMODE_ACTIVE_UV) begin
                // Undervoltage detection enabled for this setting.
                want_act = !i_transceiver_supply_uv;
                want_lst = i_transceiver_supply_uv && state_r == cantmc_pkg::XS_LISTEN;
            end else if (i_transceiver_mode_field == cantmc_pkg::XMODE_ACTIVE_NU) begin
                // Undervoltage ignored; only the supply1 reset threshold ends it.
                want_act = !i_supply1_below_reset_threshold;
            end else if (i_transceiver_mode_field == cantmc_pkg::XMODE_LISTEN) begin
                want_lst = 1'b1;
            end
        end else if (i_chip_mode_field == cantmc_pkg::CHIP_FORCED) begin
            want_act = !i_transceiver_supply_uv;
            want_lst = i_transceiver_supply_uv;
        end else if (i_chip_mode_field == cantmc_pkg::CHIP_STANDBY) begin
            want_lst = i_transceiver_mode_field == cantmc_pkg::XMODE_LISTEN;
        end
        // A low transmit pin turns any Active request into Listen-only.
        if (want_act && !i_transmit_data_pin) begin
            want_act = 1'b0;
            want_lst = 1'b1;
        end
    end

    // Next state: online states from the request, else Offline family.
    always_comb begin
        state_nxt = state_r;
        if ((mode_r == cantmc_pkg::CHIP_OFF || mode_r == cantmc_pkg::CHIP_OVERTEMP)
            && i_chip_mode_field == cantmc_pkg::CHIP_RESET) begin
            state_nxt = cantmc_pkg::XS_OFFLINE;
        end else if (want_act) begin
            state_nxt = cantmc_pkg::XS_ACTIVE;
        end else if (want_lst) begin
            state_nxt = cantmc_pkg::XS_LISTEN;
        end else begin
            case (state_r)
                cantmc_pkg::XS_ACTIVE, cantmc_pkg::XS_LISTEN: begin
                    // Leaving online: pass through Bias unless bus already silent.
                    state_nxt = silent ? cantmc_pkg::XS_OFFLINE
                                       : cantmc_pkg::XS_BIAS;
                end
                cantmc_pkg::XS_OFFLINE: begin
                    if (i_bus_edge) begin
                        state_nxt = cantmc_pkg::XS_BIAS;
                    end
                end
                cantmc_pkg::XS_BIAS: begin
                    if (silent && !i_bus_edge) begin
                        state_nxt = cantmc_pkg::XS_OFFLINE;
                    end
                end
                default: begin
                    state_nxt = cantmc_pkg::XS_OFFLINE;
                end
            endcase
        end
    end

    // Output decode from the next state so outputs come from flops.
    always_comb begin
        tx_nxt  = state_nxt == cantmc_pkg::XS_ACTIVE;
        rx_nxt  = state_nxt == cantmc_pkg::XS_ACTIVE || state_nxt == cantmc_pkg::XS_LISTEN;
        // Listen-only keeps receiver and supply bias with transmitter off.
        bs_nxt  = rx_nxt;
        ba_nxt  = state_nxt == cantmc_pkg::XS_BIAS;
        bg_nxt  = state_nxt == cantmc_pkg::XS_OFFLINE;
        wm_nxt  = (state_nxt == cantmc_pkg::XS_OFFLINE || state_nxt == cantmc_pkg::XS_BIAS)
                  && i_bus_wake_enable;
        rdy_nxt = tx_nxt;
    end

    // State and output registers.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_r <= cantmc_pkg::XS_RESET_STATE;
            mode_r  <= cantmc_pkg::CHIP_OFF;
            tx_r    <= 1'b0;
            rx_r    <= 1'b0;
            bs_r    <= 1'b0;
            ba_r    <= 1'b0;
            bg_r    <= 1'b1;
            wm_r    <= 1'b0;
            rdy_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r  <= i_chip_mode_field;
            tx_r    <= tx_nxt;
            rx_r    <= rx_nxt;
            bs_r    <= bs_nxt;
            ba_r    <= ba_nxt;
            bg_r    <= bg_nxt;
            wm_r    <= wm_nxt;
            rdy_r   <= rdy_nxt;
        end
    end

    // Port drives.
    assign o_tx_enable         = tx_r;
    assign o_rx_enable         = rx_r;
    assign o_bias_supply       = bs_r;
    assign o_bias_auto         = ba_r;
    assign o_bias_ground       = bg_r;
    assign o_wake_monitor      = wm_r;
    assign o_transceiver_ready = rdy_r;
    assign o_state             = state_r;

    AST_NO_ACTIVE_TXLOW: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (!i_transmit_data_pin && !$past(i_transmit_data_pin)) |-> !o_tx_enable)
        else $error("Transmitter enabled while transmit pin low.");

    AST_NORMAL_ACTIVE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_chip_mode_field == cantmc_pkg::CHIP_NORMAL && i_transmit_data_pin
         && i_transceiver_mode_field == cantmc_pkg::XMODE_ACTIVE_NU
         && !i_supply1_below_reset_threshold) |=> o_tx_enable)
        else $error("Active not entered for field 10.");

    AST_UV_LEAVES: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_transceiver_mode_field == cantmc_pkg::XMODE_ACTIVE_UV && i_transceiver_supply_uv)
        |=> !o_tx_enable)
        else $error("Active kept under supply undervoltage.");

    AST_LISTEN_FIELD: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_chip_mode_field == cantmc_pkg::CHIP_STANDBY
         && i_transceiver_mode_field == cantmc_pkg::XMODE_LISTEN)
        |=> (o_rx_enable && !o_tx_enable && o_bias_supply))
        else $error("Listen-only not entered in Standby.");

    AST_FORCED_UV: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_chip_mode_field == cantmc_pkg::CHIP_FORCED && i_transceiver_supply_uv)
        |=> (o_state == 4'h4))
        else $error("Forced Normal undervoltage not Listen-only.");

    AST_SLEEP_OFFLINE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (i_chip_mode_field == cantmc_pkg::CHIP_SLEEP) |=> !o_rx_enable)
        else $error("Online state in Sleep mode.");

    AST_OFFLINE_TO_BIAS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (state_r == cantmc_pkg::XS_OFFLINE && i_bus_edge
         && i_chip_mode_field == cantmc_pkg::CHIP_SLEEP && mode_r == cantmc_pkg::CHIP_SLEEP)
        |=> o_bias_auto)
        else $error("Bus activity did not raise bias.");

    AST_READY_MATCH: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_transceiver_ready == (o_state == 4'h8))
        else $error("Ready status disagrees with state.");

    AST_GROUND_OFFLINE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_bias_ground |-> (o_state == 4'h1 && !o_bias_auto))
        else $error("Ground bias outside Offline.");

    COV_ACTIVE: cover property (@(posedge i_clk_sys) o_tx_enable);
    COV_LISTEN: cover property (@(posedge i_clk_sys) o_rx_enable && !o_tx_enable);
    COV_BIAS_TO_OFF: cover property (@(posedge i_clk_sys) o_bias_auto ##1 o_bias_ground);

endmodule : cantmc_ctrl

// *** hw/cantmc_silence.sv ***
`timescale 1ns/100ps
// Bus silence timer: counts cycles since the last bus edge.
module cantmc_silence #(
    parameter int SILENCE_CYCLES = cantmc_pkg::SILENCE_CYCLES
) (
    // Clock and reset.
    input  wire logic i_clk_sys,
    input  wire logic i_reset,
    // Bus edge pulse from the receiver.
    input  wire logic i_bus_edge,
    // High once the bus has been silent longer than the timeout.
    output logic      o_silent
);

    logic [cantmc_pkg::SILENCE_CNT_W-1:0] cnt_r;   // Cycles since last edge.
    logic [cantmc_pkg::SILENCE_CNT_W-1:0] cnt_nxt; // Next counter value.
    logic                                 sil_r;   // Timeout reached flag.
    logic                                 sil_nxt; // Next flag value.

    // Counter clears on every edge and saturates at the terminal count.
    always_comb begin
        cnt_nxt = cnt_r;
        sil_nxt = sil_r;
        if (i_bus_edge) begin
            cnt_nxt = '0;
            sil_nxt = 1'b0;
        end else if (cnt_r >= cantmc_pkg::SILENCE_CNT_W'(SILENCE_CYCLES)) begin
            sil_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    // Registers; the bus is taken as not silent after reset.
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            cnt_r <= '0;
            sil_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            sil_r <= sil_nxt;
        end
    end

    assign o_silent = sil_r;

    AST_SILENCE_CLEARS: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_bus_edge |=> !o_silent)
        else $error("Silence flag not cleared by a bus edge.");

endmodule : cantmc_silence

// *** shared/cantmc_pkg.sv ***
package cantmc_pkg;

    // Chip operating mode codes on the chip mode field.
    localparam logic [2:0] CHIP_NORMAL   = 3'h7;
    localparam logic [2:0] CHIP_STANDBY  = 3'h4;
    localparam logic [2:0] CHIP_SLEEP    = 3'h1;
    localparam logic [2:0] CHIP_RESET    = 3'h3;
    localparam logic [2:0] CHIP_FAILSAFE = 3'h2;
    localparam logic [2:0] CHIP_OFF      = 3'h0;
    localparam logic [2:0] CHIP_OVERTEMP = 3'h5;
    localparam logic [2:0] CHIP_FORCED   = 3'h6;

    // Transceiver mode field codes.
    localparam logic [1:0] XMODE_OFFLINE   = 2'h0;
    localparam logic [1:0] XMODE_ACTIVE_UV = 2'h1;
    localparam logic [1:0] XMODE_ACTIVE_NU = 2'h2;
    localparam logic [1:0] XMODE_LISTEN    = 2'h3;

    // Bus silence timeout in microseconds and the matching clock count at 100 MHz.
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          SILENCE_TIMEOUT_US = 1000;
    localparam int          SILENCE_CYCLES     = SILENCE_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int          SILENCE_CNT_W      = 17;

    // Transceiver states, one-hot.
    typedef enum logic [3:0] {
        XS_OFFLINE = 4'h1,
        XS_BIAS    = 4'h2,
        XS_LISTEN  = 4'h4,
        XS_ACTIVE  = 4'h8
    } cantmc_state_type;

    localparam cantmc_state_type XS_RESET_STATE = XS_OFFLINE;

endpackage : cantmc_pkg

// *** testbench/cantmc_ctrl_test.sv ***
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module cantmc_ctrl_test;
    localparam int SIL = 20;            // Shortened silence count for simulation.
    logic       i_clk_sys = 1'b0;       // System clock.
    logic       i_reset = 1'b1;         // Synchronous reset.
    logic [2:0] i_chip_mode_field = 3'h0; // Chip mode.
    logic [1:0] i_transceiver_mode_field = 2'h0; // Transceiver mode.
    logic       i_bus_wake_enable = 1'b0; // Wake watch enable.
    logic       i_transceiver_supply_uv = 1'b0; // Supply low flag.
    logic       i_supply1_below_reset_threshold = 1'b0; // Supply1 low flag.
    logic       stuck = 1'b0;           // Transmit pin held low by the host.
    logic       traffic = 1'b0;         // Bus carries edges.
    logic       i_transmit_data_pin;    // From host model.
    logic       i_bus_edge;             // From host model.
    logic       o_tx_enable, o_rx_enable, o_bias_supply, o_bias_auto;
    logic       o_bias_ground, o_wake_monitor, o_transceiver_ready;
    logic [3:0] o_state;                // One-hot state.
    logic [3:0] exp_s = 4'h1;           // Model state.
    logic [31:0] r;                     // Random word.
    logic [2:0] modes [6];              // Modes drawn at random.
    int         seed = 49483;           // Fixed seed.
    int         miscompares = 0;        // Mismatch count.
    int         check_count = 0;        // Comparison count.

    // Half-period toggle gives 100 MHz.
    always #5 i_clk_sys = ~i_clk_sys;

    cantmc_ctrl #(.SILENCE_CYCLES(SIL)) DUT (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_chip_mode_field(i_chip_mode_field),
        .i_transceiver_mode_field(i_transceiver_mode_field),
        .i_bus_wake_enable(i_bus_wake_enable),
        .i_transceiver_supply_uv(i_transceiver_supply_uv),
        .i_supply1_below_reset_threshold(i_supply1_below_reset_threshold),
        .i_transmit_data_pin(i_transmit_data_pin), .i_bus_edge(i_bus_edge),
        .o_tx_enable(o_tx_enable), .o_rx_enable(o_rx_enable),
        .o_bias_supply(o_bias_supply), .o_bias_auto(o_bias_auto),
        .o_bias_ground(o_bias_ground), .o_wake_monitor(o_wake_monitor),
        .o_transceiver_ready(o_transceiver_ready), .o_state(o_state));

    cantmc_host_model host (
        .i_clk_sys(i_clk_sys), .i_stuck_low(stuck), .i_traffic(traffic),
        .o_transmit_data_pin(i_transmit_data_pin), .o_bus_edge(i_bus_edge));

    // Reference decision from the chip mode, field, supply, pin and bus activity.
    function automatic logic [3:0] predict(input logic [2:0] m, input logic [1:0] f,
                                           input logic uv, input logic tx,
                                           input logic busy, input logic [3:0] cur,
                                           input logic s1);
        logic [3:0] idle;
        idle = busy ? 4'h2 : 4'h1;
        predict = idle;
        if (m == cantmc_pkg::CHIP_FORCED) begin
            predict = (uv || !tx) ? 4'h4 : 4'h8;
        end else if (m == cantmc_pkg::CHIP_STANDBY && f == cantmc_pkg::XMODE_LISTEN) begin
            predict = 4'h4;
        end else if (m == cantmc_pkg::CHIP_NORMAL) begin
            if (f == cantmc_pkg::XMODE_LISTEN) predict = 4'h4;
            else if (f == cantmc_pkg::XMODE_ACTIVE_UV && uv)
                predict = (cur == 4'h4) ? 4'h4 : idle;
            else if (f == cantmc_pkg::XMODE_ACTIVE_NU && s1) predict = idle;
            else if (f != cantmc_pkg::XMODE_OFFLINE) predict = tx ? 4'h8 : 4'h4;
        end
    endfunction : predict

    // Lets n edges pass and lands just after the last one.
    task automatic step(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : step

    // Compares every output with what the model state implies.
    task automatic check_outs(input logic [3:0] s);
        `CHK(o_state, s)
        `CHK(o_tx_enable, s[3])
        `CHK(o_rx_enable, s[3] | s[2])
        `CHK(o_bias_supply, s[3] | s[2])
        `CHK(o_bias_auto, s[1])
        `CHK(o_bias_ground, s[0])
        `CHK(o_wake_monitor, (s[0] | s[1]) & i_bus_wake_enable)
        `CHK(o_transceiver_ready, s[3])
    endtask : check_outs

    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("Counts: %0d compared, %0d mismatched", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out

    // Main sequence: reset, power-up path, then randomised mode steps.
    initial begin
        modes = '{cantmc_pkg::CHIP_NORMAL, cantmc_pkg::CHIP_FORCED, cantmc_pkg::CHIP_STANDBY,
                  cantmc_pkg::CHIP_SLEEP, cantmc_pkg::CHIP_FAILSAFE, cantmc_pkg::CHIP_RESET};
        step(2);
        i_reset = 1'b0;
        check_outs(4'h1);
        step(3);
        i_chip_mode_field = cantmc_pkg::CHIP_RESET;
        step(3);
        check_outs(4'h1);
        $display("test power_up done");
        for (int i = 0; i < 80; i++) begin
            r = $random(seed);
            i_chip_mode_field = modes[r[2:0] % 6];
            i_transceiver_mode_field = r[4:3];
            i_transceiver_supply_uv = r[5];
            i_bus_wake_enable = r[6];
            stuck = (r[8:7] == 2'h0);
            i_supply1_below_reset_threshold = r[9];
            traffic = 1'b1;
            step(5);
            exp_s = predict(i_chip_mode_field, r[4:3], r[5], !stuck, 1'b1, exp_s, r[9]);
            check_outs(exp_s);
            traffic = 1'b0;
            step(SIL + 10);
            exp_s = predict(i_chip_mode_field, r[4:3], r[5], !stuck, 1'b0, exp_s, r[9]);
            check_outs(exp_s);
        end
        $display("test random_modes done");
        close_out();
    end

    // Cuts a hang short well past the expected run length.
    initial begin
        #60000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule : cantmc_ctrl_test

// *** testbench/cantmc_host_model.sv ***
`timescale 1ns/100ps
// Host controller and bus stand-in: holds the transmit pin and makes bus edges.
module cantmc_host_model (
    // Clock.
    input  wire logic i_clk_sys,
    // Bench commands.
    input  wire logic i_stuck_low,
    input  wire logic i_traffic,
    // Pins toward the transceiver logic.
    output logic      o_transmit_data_pin,
    output logic      o_bus_edge
);
    // Recessive high unless a short to ground on the pin is being modelled.
    assign o_transmit_data_pin = ~i_stuck_low;

    // One edge pulse each cycle while the bus carries traffic, none when silent.
    always_ff @(posedge i_clk_sys) begin
        o_bus_edge <= i_traffic;
    end
endmodule : cantmc_host_model
